// ==== srw_pkg.sv ====
// Purpose: Shared constants, bus carriers and state types for the timing
//          reference capture windowing block.
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register.
// Notes:   Register constants are word indexes; byte address is index * 4.
package srw_pkg;

  localparam int unsigned TAPS       = 24;
  localparam int unsigned SEL_W      = 4;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned IDX_W      = 8;

  localparam logic [7:0] IDX_MAP_LOW  = 8'h2c;
  localparam logic [7:0] IDX_MAP_MID  = 8'h2d;
  localparam logic [7:0] IDX_MAP_HIGH = 8'h2e;
  localparam logic [7:0] IDX_CTRL     = 8'h30;
  localparam logic [7:0] IDX_PERIOD   = 8'h31;
  localparam logic [7:0] IDX_STATUS   = 8'h32;

  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned CTRL_FINE_BIT = 4;
  localparam int unsigned CTRL_MODE_BIT = 8;
  localparam int unsigned STAT_SEEN_BIT = 16;

  localparam logic [SEL_W-1:0] SEL_RESET    = 4'h0;
  localparam logic             FINE_RESET   = 1'b1;
  localparam logic             MODE_RESET   = 1'b0;
  localparam logic [CNT_W-1:0] PERIOD_RESET = 16'h0020;
  localparam logic [TAPS-1:0]  MAP_RESET    = 24'hffffff;
  localparam logic [TAPS-1:0]  MAP_ENDS     = 24'h800001;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Mode bit value: 0 selects 8B/10B framing, 1 selects 64B/66B framing.
  localparam logic MODE_64B66B = 1'b1;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } srw_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } srw_axi_rsp_t;

  typedef struct packed {
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             aw_held;
    logic             w_held;
    logic [IDX_W-1:0] awidx;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [SEL_W-1:0] sel;
    logic             fine;
    logic             mode;
    logic [CNT_W-1:0] period;
    logic [TAPS-1:0]  risk_map;
    logic             cap_prev;
    logic             capture;
    logic             seen;
    logic [CNT_W-1:0] frame_cnt;
    logic             lmfc_edge;
    logic             lemc_edge;
  } srw_state_t;

endpackage

// ==== srw_sync3.sv ====
// Purpose: Three-stage synchroniser with agreement filter for tap samples.
// Assumes: Inputs are asynchronous to i_mclk.
// Notes:   A bit moves to o_stable only when stages two and three agree.
`timescale 1ns/1ps
module srw_sync3 #(
  parameter int unsigned W = 24
) (
  input  wire logic         i_mclk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_stable
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] stable;
  } srw_sync_t;

  srw_sync_t s;
  srw_sync_t next_s;
  logic [W-1:0] agree;

  assign agree = s.ff2 ~^ s.ff3;

  always_comb begin
    next_s        = s;
    next_s.ff1    = i_async;
    next_s.ff2    = s.ff1;
    next_s.ff3    = s.ff2;
    next_s.stable = (agree & s.ff3) | (~agree & s.stable);
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_stable = s.stable;

  a_stable_on_agree: assert property ( // see [RQ5]
    @(posedge i_mclk) disable iff (i_srst)
    ((o_stable ^ $past(o_stable)) & ~$past(agree)) == '0)
    else $error("stable output changed without stage agreement");

endmodule

// ==== srw_window_top.sv ====
// Purpose: Timing reference capture with a 24-position risk detector,
//          selectable capture tap and frame counter reset.
// Assumes: An external delay line samples the reference at 24 delayed
//          copies of the device clock edge, with its step size set by o_fine_delay_step.
// Notes:   Registers are reached over AXI4-Lite.
// How it works
// [RQ1] The reference is always captured at one fixed, selected tap edge.
// [RQ2] The source may send one pulse or a periodic reference.
// [RQ3] 8B/10B periodic reference divides the multiframe clock rate.
// [RQ4] 64B/66B periodic reference divides the extended multiblock rate.
// [RQ5] A window scheme replaces setup and hold limits on the reference.
// [RQ6] Twenty-four candidate positions each map to one read-only map bit.
// [RQ7] A map bit reads 1 for risky positions and 0 for safe ones.
// [RQ8] Map bits 0 and 23 always read 1.
// [RQ9] The select field indexes the map bit whose tap captures the reference.
// [RQ10] Select reaches taps 0 to 15 only; taps 16 to 23 inform.
// [RQ11] A step bit picks coarse (0) or fine (1) delay steps.
// [RQ12] Software should keep fine steps unless no transition shows.
// [RQ13] Apply clock and reference first, then read map and program select.
// [RQ14] Pick the safe midpoint; prefer lower select values on ties.
// [RQ15] The best select may be found once and reapplied at power-up.
// [RQ16] A capture resets the multiframe or extended multiblock counter.
// [RQ17] The map keeps tracking reference edges; writes to it are ignored.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module srw_window_top #(
  parameter int unsigned TAPS  = srw_pkg::TAPS,
  parameter int unsigned CNT_W = srw_pkg::CNT_W
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_srst,
  input  wire srw_pkg::srw_axi_req_t i_axi,
  output srw_pkg::srw_axi_rsp_t      o_axi,
  input  wire logic [TAPS-1:0]       i_tap_samples,
  output logic                       o_fine_delay_step,
  output logic                       o_sysref_capture,
  output logic                       o_lmfc_edge,
  output logic                       o_lemc_edge
);

  srw_pkg::srw_state_t s;
  srw_pkg::srw_state_t next_s;

  logic [TAPS-1:0] taps;
  logic [TAPS-1:0] risk;
  logic            mixed;
  logic            cur_tap;
  logic            evt;
  logic            wr_go;
  logic [7:0]      ridx;

  // The delay line outputs are asynchronous; all of them are filtered alike
  // so that a boundary between taps cannot be seen one cycle skewed.
  srw_sync3 #(
    .W (TAPS)
  ) u_sync (
    .i_mclk   (i_mclk),
    .i_srst   (i_srst),
    .i_async  (i_tap_samples),
    .o_stable (taps)
  );

  // One risk bit per candidate tap position.
  genvar gi;
  generate
    for (gi = 0; gi < TAPS; gi++) begin : g_risk // see [RQ6]
      if (gi == 0 || gi == TAPS - 1) begin : g_end
        assign risk[gi] = 1'b1; // see [RQ8]
      end else begin : g_mid
        // A tap next to a level change sits on the edge of the reference.
        assign risk[gi] = (taps[gi] ^ taps[gi-1]) |
                          (taps[gi] ^ taps[gi+1]); // see [RQ7]
      end
    end
  endgenerate

  assign mixed   = (taps != '0) && (taps != '1);
  // The select is only four bits wide, so taps 16 and up cannot be chosen.
  assign cur_tap = taps[s.sel]; // see [RQ9] [RQ10]
  assign evt     = cur_tap & ~s.cap_prev;
  assign wr_go   = s.aw_held && s.w_held && !s.bvalid;
  assign ridx    = i_axi.araddr[9:2];

  function automatic logic [7:0] merge8(input logic [7:0] old_v,
                                        input logic [7:0] new_v,
                                        input logic       en);
    merge8 = en ? new_v : old_v;
  endfunction

  always_comb begin
    next_s           = s;
    next_s.lmfc_edge = 1'b0;
    next_s.lemc_edge = 1'b0;
    next_s.capture   = 1'b0;

    if (i_axi.awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awidx   = i_axi.awaddr[9:2];
      next_s.awready = 1'b0;
    end
    if (i_axi.wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = i_axi.wdata;
      next_s.wstrb  = i_axi.wstrb;
      next_s.wready = 1'b0;
    end
    if (s.bvalid && i_axi.bready) begin
      next_s.bvalid  = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
    end

    // Detector first, so that a step-size write below can override it.
    if (mixed) begin
      next_s.risk_map = risk; // see [RQ17]
    end

    if (wr_go) begin
      next_s.bvalid  = 1'b1;
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bresp   = srw_pkg::RESP_OKAY;
      unique case (s.awidx)
        srw_pkg::IDX_CTRL: begin
          if (s.wstrb[0]) begin
            next_s.sel  = s.wdata[srw_pkg::CTRL_SEL_LSB +: srw_pkg::SEL_W];
            next_s.fine = s.wdata[srw_pkg::CTRL_FINE_BIT]; // see [RQ11]
            // A new step size makes the old map meaningless until the
            // next reference edge refreshes it.
            if (s.wdata[srw_pkg::CTRL_FINE_BIT] != s.fine) begin
              next_s.risk_map = srw_pkg::MAP_RESET;
            end
          end
          if (s.wstrb[1]) begin
            next_s.mode = s.wdata[srw_pkg::CTRL_MODE_BIT];
          end
        end
        srw_pkg::IDX_PERIOD: begin
          next_s.period = {merge8(s.period[15:8], s.wdata[15:8], s.wstrb[1]),
                           merge8(s.period[7:0], s.wdata[7:0], s.wstrb[0])};
        end
        srw_pkg::IDX_MAP_LOW, srw_pkg::IDX_MAP_MID, srw_pkg::IDX_MAP_HIGH,
        srw_pkg::IDX_STATUS: begin
          next_s.bresp = srw_pkg::RESP_OKAY; // see [RQ17]
        end
        default: begin
          next_s.bresp = srw_pkg::RESP_SLVERR;
        end
      endcase
    end

    if (i_axi.arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rresp   = srw_pkg::RESP_OKAY;
      unique case (ridx)
        srw_pkg::IDX_MAP_LOW:  next_s.rdata = {24'h000000, s.risk_map[7:0]};
        srw_pkg::IDX_MAP_MID:  next_s.rdata = {24'h000000, s.risk_map[15:8]};
        srw_pkg::IDX_MAP_HIGH: next_s.rdata = {24'h000000, s.risk_map[23:16]};
        srw_pkg::IDX_CTRL:
          next_s.rdata = {23'h000000, s.mode, 3'h0, s.fine, s.sel};
        srw_pkg::IDX_PERIOD:   next_s.rdata = {16'h0000, s.period};
        srw_pkg::IDX_STATUS:   next_s.rdata = {15'h0000, s.seen, s.frame_cnt};
        default: begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = srw_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && i_axi.rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end

    // Capture tracks the selected tap only; changing the select while the
    // reference is high may report one extra capture.
    next_s.cap_prev = cur_tap; // see [RQ1]
    if (evt) begin
      next_s.capture   = 1'b1;
      next_s.seen      = 1'b1;
      next_s.frame_cnt = '0; // see [RQ16]
    end else if ((CNT_W'(s.frame_cnt + 1'b1)) >= s.period) begin
      next_s.frame_cnt = '0;
    end else begin
      next_s.frame_cnt = CNT_W'(s.frame_cnt + 1'b1);
    end
    if (next_s.frame_cnt == '0) begin
      next_s.lmfc_edge = (s.mode != srw_pkg::MODE_64B66B); // see [RQ16]
      next_s.lemc_edge = (s.mode == srw_pkg::MODE_64B66B);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s          <= '0;
      s.awready  <= 1'b1;
      s.wready   <= 1'b1;
      s.arready  <= 1'b1;
      s.sel      <= srw_pkg::SEL_RESET;
      s.fine     <= srw_pkg::FINE_RESET;
      s.mode     <= srw_pkg::MODE_RESET;
      s.period   <= srw_pkg::PERIOD_RESET;
      s.risk_map <= srw_pkg::MAP_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign o_axi.awready     = s.awready;
  assign o_axi.wready      = s.wready;
  assign o_axi.bvalid      = s.bvalid;
  assign o_axi.bresp       = s.bresp;
  assign o_axi.arready     = s.arready;
  assign o_axi.rvalid      = s.rvalid;
  assign o_axi.rdata       = s.rdata;
  assign o_axi.rresp       = s.rresp;
  assign o_fine_delay_step = s.fine;
  assign o_sysref_capture  = s.capture;
  assign o_lmfc_edge       = s.lmfc_edge;
  assign o_lemc_edge       = s.lemc_edge;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);

  sequence seq_ctrl_write;
    wr_go && s.awidx == srw_pkg::IDX_CTRL && s.wstrb[0];
  endsequence

  sequence seq_map_low_read;
    i_axi.arvalid && s.arready && ridx == srw_pkg::IDX_MAP_LOW;
  endsequence

  a_map_ends_set: assert property ( // see [RQ8]
    (s.risk_map & srw_pkg::MAP_ENDS) == srw_pkg::MAP_ENDS)
    else $error("map end bits not set");

  a_map_follows_taps: assert property ( // see [RQ7]
    mixed && !wr_go |=> s.risk_map == $past(risk))
    else $error("map did not follow tap pattern");

  a_capture_on_sel: assert property ( // see [RQ9]
    evt |=> o_sysref_capture && s.cap_prev && s.seen)
    else $error("capture not tied to selected tap");

  a_capture_resets: assert property ( // see [RQ16]
    evt |=> s.frame_cnt == '0 ##1
            (s.frame_cnt == CNT_W'(1) || evt || s.period <= CNT_W'(1)))
    else $error("capture did not reset frame counter");

  a_mode_pulse: assert property ( // see [RQ16]
    evt |=> (o_lmfc_edge != o_lemc_edge) &&
            (o_lemc_edge == (s.mode == srw_pkg::MODE_64B66B)))
    else $error("frame pulse on wrong output");

  a_step_drive: assert property ( // see [RQ11]
    seq_ctrl_write |=> o_fine_delay_step ==
                       $past(s.wdata[srw_pkg::CTRL_FINE_BIT]))
    else $error("step bit not driven to delay line");

  a_map_readback: assert property ( // see [RQ6]
    seq_map_low_read |=> o_axi.rvalid &&
                         o_axi.rdata[7:0] == $past(s.risk_map[7:0]))
    else $error("map read returned wrong value");

  a_map_write_blind: assert property ( // see [RQ17]
    wr_go && s.awidx == srw_pkg::IDX_MAP_LOW && !mixed
    |=> s.risk_map == $past(s.risk_map))
    else $error("write changed the risk map");

  a_write_answer: assert property ( // AXI4-Lite write handshake, our own choice
    wr_go |=> o_axi.bvalid [*1] ##0 !o_axi.awready && !o_axi.wready)
    else $error("write response missing");

endmodule

// ==== srw_ref_src.sv ====
// Purpose: Far-side model of the clock source that sends the timing
//          reference; it yields the 24 tap samples the delay line would see.
// Assumes: A fire request launches one reference pulse; i_pos is the first
//          tap whose delayed edge lands after the reference rises.
// Notes:   Between pulses the reference is low, which is its real level.
`timescale 1ns/1ps
module srw_ref_src (
  input  wire logic        i_mclk,
  input  wire logic        i_fire,
  input  wire logic [4:0]  i_pos,
  output logic      [23:0] o_taps
);
  logic [2:0] phase = 3'h0;
  initial o_taps = 24'h000000;
  // Taps below the edge still see low, taps at and above it see high; the
  // pulse then stays high on every tap for a few cycles.
  always @(posedge i_mclk) begin
    if (i_fire) begin
      o_taps <= ~((24'h000001 << i_pos) - 24'h000001);
      phase  <= 3'h4;
    end else if (phase != 3'h0) begin
      o_taps <= 24'hffffff;
      phase  <= phase - 3'h1;
    end else begin
      o_taps <= 24'h000000;
    end
  end
endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench for the reference capture windowing block.
// Assumes: Clock and reference are applied before the map is read, except for the reset-value read.
// Notes:   Handshakes are sampled on the falling edge, where every design
//          output is settled, and released on the next rising edge.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [4:0]  pos;
    logic [23:0] map;
  } srw_tb_row_t;
  logic                  i_mclk = 1'b0;
  logic                  i_srst = 1'b1;
  srw_pkg::srw_axi_req_t req    = '0;
  srw_pkg::srw_axi_rsp_t rsp;
  logic [23:0]           taps;
  logic                  fire   = 1'b0;
  logic [4:0]            pos    = 5'h00;
  logic                  fine_o, cap_o, lmfc_o, lemc_o;
  logic                  mode   = 1'b0;
  logic [1:0]            r;
  logic [31:0]           d;
  logic [23:0]           m;
  srw_tb_row_t           rows [5];
  int miscompares = 0;
  int compares    = 0;
  int cyc = 0, ncap = 0, n0 = 0, last_lmfc = 0, gap = 0;

  always #5 i_mclk = ~i_mclk;

  srw_window_top srw_window_top_inst (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_axi(req), .o_axi(rsp),
    .i_tap_samples(taps), .o_fine_delay_step(fine_o),
    .o_sysref_capture(cap_o), .o_lmfc_edge(lmfc_o), .o_lemc_edge(lemc_o));
  srw_ref_src srw_ref_src_inst (
    .i_mclk(i_mclk), .i_fire(fire), .i_pos(pos), .o_taps(taps));

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v,
                        output logic [1:0] resp);
    logic aw, w, b;
    aw = 1'b0; w = 1'b0; b = 1'b0;
    @(posedge i_mclk);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= v; req.wstrb <= 4'hf; req.bready <= 1'b1;
    while (!b) begin
      @(negedge i_mclk);
      aw = req.awvalid && rsp.awready === 1'b1;
      w = req.wvalid && rsp.wready === 1'b1;
      b = rsp.bvalid === 1'b1;
      resp = rsp.bresp;
      @(posedge i_mclk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b) req.bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v,
                        output logic [1:0] resp);
    logic ar, rv;
    ar = 1'b0; rv = 1'b0;
    @(posedge i_mclk);
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    while (!rv) begin
      @(negedge i_mclk);
      ar = req.arvalid && rsp.arready === 1'b1;
      rv = rsp.rvalid === 1'b1;
      v = rsp.rdata; resp = rsp.rresp;
      @(posedge i_mclk);
      if (ar) req.arvalid <= 1'b0;
      if (rv) req.rready <= 1'b0;
    end
  endtask

  task automatic rd_map(output logic [23:0] mv);
    logic [31:0] l, mi, h;
    logic [1:0]  rr;
    axi_rd(12'hb0, l, rr);
    axi_rd(12'hb4, mi, rr);
    axi_rd(12'hb8, h, rr);
    mv = {h[7:0], mi[7:0], l[7:0]};
  endtask

  task automatic fire_at(input logic [4:0] p);
    @(posedge i_mclk);
    fire <= 1'b1; pos <= p;
    @(posedge i_mclk);
    fire <= 1'b0;
    repeat (14) @(posedge i_mclk);
  endtask

  // Captures are watched every cycle: a pulse on the wrong frame output or
  // a missing one shows up here even when no register read follows.
  always @(negedge i_mclk) begin
    cyc++;
    if (!i_srst && cap_o === 1'b1) begin
      ncap++;
      chk(32'(mode ? lemc_o : lmfc_o), 32'h1, "frame edge");
    end
    if (lmfc_o === 1'b1) begin
      gap = cyc - last_lmfc;
      last_lmfc = cyc;
    end
    if (cyc > 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    rows[0] = '{5'd1,  24'h800003};
    rows[1] = '{5'd5,  24'h800031};
    rows[2] = '{5'd12, 24'h801801};
    rows[3] = '{5'd16, 24'h818001};
    rows[4] = '{5'd23, 24'hc00001};
    repeat (12) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(negedge i_mclk);
    chk(32'(fine_o), 32'h1, "fine after reset");
    axi_rd(12'hc0, d, r);
    chk(d, 32'h10, "ctrl reset");
    axi_rd(12'hc4, d, r);
    chk(d, 32'h20, "period reset");
    rd_map(m);
    chk(32'(m), 32'hffffff, "map reset");
    // The reference is applied before each map read.
    foreach (rows[i]) begin
      n0 = ncap;
      fire_at(rows[i].pos);
      rd_map(m);
      chk(32'(m), 32'(rows[i].map), "risk map");
      chk(32'(ncap - n0), 32'h1, "one capture");
    end
    axi_wr(12'hb0, 32'h0, r);
    chk(32'(r), 32'(srw_pkg::RESP_OKAY), "map write resp");
    rd_map(m);
    chk(32'(m), 32'hc00001, "map write ignored");
    axi_rd(12'hfc, d, r);
    chk(32'(r), 32'(srw_pkg::RESP_SLVERR), "unmapped resp");
    chk(d, 32'h0, "unmapped data");
    axi_wr(12'hc0, 32'h0, r);
    @(negedge i_mclk);
    chk(32'(fine_o), 32'h0, "coarse step");
    rd_map(m);
    chk(32'(m), 32'hffffff, "map cleared");
    // A period of 8 stands for a multiframe length the reference divides.
    axi_wr(12'hc4, 32'h8, r);
    // Fine steps back on; a stored select is reapplied as at power-up.
    axi_wr(12'hc0, 32'h1f, r);
    axi_rd(12'hc0, d, r);
    chk(d, 32'h1f, "top select");
    n0 = ncap;
    fire_at(5'd12);
    repeat (20) @(posedge i_mclk);
    chk(32'(gap), 32'h8, "frame period");
    chk(32'(ncap - n0), 32'h1, "capture tap 15");
    // Lowest safe select for an edge at tap 3 with margin: tap 5.
    axi_wr(12'hc0, 32'h115, r);
    mode = 1'b1;
    n0 = ncap;
    fire_at(5'd3);
    chk(32'(ncap - n0), 32'h1, "capture 64b66b");
    axi_rd(12'hc8, d, r);
    chk(32'(d[16]), 32'h1, "seen flag");
    wrap_up();
  end
endmodule
